// [common/pio_pkg.sv]
`default_nettype none
package pio_pkg;

   // Port count, pin width per port and the register bus shape.
   localparam int NPORT     = 7;
   localparam int PIN_W     = 16;
   localparam int ADDR_W    = 8;
   localparam int DATA_W    = 32;
   localparam int MAX_LINES = 79;

   // Port indices: address/data port, address port, then ports 3, 4, 5, 9, 20.
   localparam int P_AD   = 0;
   localparam int P_ADDR = 1;
   localparam int P_3    = 2;
   localparam int P_4    = 3;
   localparam int P_IN   = 4;
   localparam int P_9    = 5;
   localparam int P_20   = 6;

   localparam int PORT_W_DEF [NPORT] = '{16, 16, 15, 8, 14, 6, 4};

   // Feature bits, one per port index.
   localparam logic [NPORT-1:0] HAS_OUT = 7'h6f;
   localparam logic [NPORT-1:0] HAS_OD  = 7'h6c;
   localparam logic [NPORT-1:0] HAS_THR = 7'h2c;
   localparam logic [NPORT-1:0] HAS_PAD = 7'h6f;

   // Each port owns a 32-byte block; block 7 holds the global registers.
   localparam logic [2:0] GLB_BLOCK = 3'h7;
   localparam logic [4:0] OFS_DATA  = 5'h00;
   localparam logic [4:0] OFS_DIR   = 5'h04;
   localparam logic [4:0] OFS_ODC   = 5'h08;
   localparam logic [4:0] OFS_ALT   = 5'h0c;
   localparam logic [4:0] OFS_PAD   = 5'h10;
   localparam logic [4:0] OFS_THR   = 5'h14;
   localparam logic [4:0] OFS_BUS   = 5'h00;
   localparam logic [4:0] OFS_SYS   = 5'h04;

   // Write select lines into a port, one per register.
   localparam int SEL_DATA = 0;
   localparam int SEL_DIR  = 1;
   localparam int SEL_ODC  = 2;
   localparam int SEL_ALT  = 3;
   localparam int SEL_PAD  = 4;
   localparam int SEL_THR  = 5;
   localparam int NSEL     = 6;

   // Global bus configuration field positions, then the reset release bit of the system register.
   localparam int BIT_MUX     = 0;
   localparam int BIT_DEMUX   = 1;
   localparam int BIT_SEG     = 2;
   localparam int BIT_CAN_SEL = 3;
   localparam int BIT_RST_REL = 0;

   // Pin masks for the CAN lines and the segment address lines.
   localparam logic [15:0] CAN4_TXM = 16'h0080;
   localparam logic [15:0] CAN4_RXM = 16'h0040;
   localparam logic [15:0] CAN9_TXM = 16'h0002;
   localparam logic [15:0] CAN9_RXM = 16'h0001;
   localparam logic [15:0] SEG_MASK = 16'h00ff;

   // Values after reset.
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [1:0]  RST_THR  = 2'h0;
   localparam logic [3:0]  RST_BUS  = 4'h0;
   localparam logic        RST_SYS  = 1'b0;
   localparam logic        RST_WAIT = 1'b1;

   function automatic logic [15:0] masked_write(input logic [15:0] old,
                                                input logic [15:0] data,
                                                input logic [15:0] mask);
      masked_write = (old & ~mask) | (data & mask);
   endfunction

endpackage
`default_nettype wire

// [rtl/pio_port.sv]
`default_nettype none
module pio_port #(
   parameter int   W       = 16,
   parameter logic HAS_OUT = 1'b1,
   parameter logic HAS_OD  = 1'b0,
   parameter logic HAS_THR = 1'b0,
   parameter logic HAS_PAD = 1'b1
) (
   // Clock and reset.
   input  wire logic                     core_clk,
   input  wire logic                     rst_n,
   // Register writes.
   input  wire logic [15:0]              wr_data,
   input  wire logic [15:0]              wr_mask,
   input  wire logic [pio_pkg::NSEL-1:0] wr_sel,
   // Function override.
   input  wire logic [15:0]              ovr_en,
   input  wire logic [15:0]              ovr_out,
   input  wire logic [15:0]              ovr_oe,
   // Pins.
   input  wire logic [15:0]              pin_in,
   output logic      [15:0]              pin_out,
   output logic      [15:0]              pin_oe,
   output logic      [15:0]              pin_sync,
   // Register values.
   output logic      [15:0]              rd_data,
   output logic      [15:0]              rd_dir,
   output logic      [15:0]              rd_odc,
   output logic      [15:0]              rd_alt,
   output logic      [15:0]              rd_pad,
   output logic      [1:0]               rd_thr
);

   localparam logic [15:0] VMASK = 16'((32'h1 << W) - 32'h1);
   localparam logic [15:0] OMASK = HAS_OUT ? VMASK : 16'h0000;
   localparam logic [15:0] DMASK = HAS_OD ? OMASK : 16'h0000;
   localparam logic [15:0] PMASK = HAS_PAD ? 16'hffff : 16'h0000;
   localparam logic [1:0]  TMASK = HAS_THR ? {W > 8, 1'b1} : 2'h0;

   logic [15:0] out_q;
   logic [15:0] sync_a;
   wire  [15:0] m_out  = wr_mask & OMASK;
   wire  [15:0] gp_out = rd_dir & ~ovr_en;
   wire  [15:0] drv_out = (ovr_en & ovr_out) | (~ovr_en & out_q);
   wire  [15:0] drv_oe  = (ovr_en & ovr_oe) | (~ovr_en & rd_dir);
   // Open drain never drives high: it only enables the driver for a zero.
   wire  [15:0] next_pin_oe  = drv_oe & ~(rd_odc & drv_out)
                             & OMASK;
   wire  [15:0] next_pin_out = drv_out & ~rd_odc & OMASK;
   // Each threshold bit follows its own mask bit, like every other register.
   wire  [1:0]  t_mask = wr_mask[1:0] & TMASK;

   // Output lines with no override read back their latch, all others the synced pin.
   assign rd_data = ((gp_out & out_q) | (~gp_out & pin_sync))
                  & VMASK;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_a   <= pio_pkg::RST_WORD;
         pin_sync <= pio_pkg::RST_WORD;
      end else begin
         sync_a   <= pin_in & VMASK;
         pin_sync <= sync_a;
      end
   end

   // Masked writes touch only the selected bits of a register.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_q  <= pio_pkg::RST_WORD;
         rd_dir <= pio_pkg::RST_WORD;
         rd_odc <= pio_pkg::RST_WORD;
         rd_alt <= pio_pkg::RST_WORD;
         rd_pad <= pio_pkg::RST_WORD;
         rd_thr <= pio_pkg::RST_THR;
      end else begin
         if (wr_sel[pio_pkg::SEL_DATA])
            out_q <= pio_pkg::masked_write(out_q, wr_data, m_out);
         if (wr_sel[pio_pkg::SEL_DIR])
            rd_dir <= pio_pkg::masked_write(rd_dir, wr_data,
                                            m_out);
         if (wr_sel[pio_pkg::SEL_ODC])
            rd_odc <= pio_pkg::masked_write(rd_odc, wr_data, wr_mask & DMASK);
         if (wr_sel[pio_pkg::SEL_ALT])
            rd_alt <= pio_pkg::masked_write(rd_alt, wr_data, wr_mask & VMASK);
         if (wr_sel[pio_pkg::SEL_PAD])
            rd_pad <= pio_pkg::masked_write(rd_pad, wr_data, wr_mask & PMASK);
         if (wr_sel[pio_pkg::SEL_THR])
            rd_thr <= (rd_thr & ~t_mask) | (wr_data[1:0] & t_mask);
      end
   end

   // Reset clears every enable, so each pin floats as an input.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_out <= pio_pkg::RST_WORD;
         pin_oe  <= pio_pkg::RST_WORD;
      end else begin
         pin_out <= next_pin_out;
         pin_oe  <= next_pin_oe;
      end
   end

endmodule
`default_nettype wire

// [rtl/pio_top.sv]
`default_nettype none
module pio_top #(
   parameter int PORT_W [pio_pkg::NPORT] = pio_pkg::PORT_W_DEF
) (
   // Clock and reset.
   input  wire logic                                  core_clk,
   input  wire logic                                  rst_n,
   // Avalon-MM slave.
   input  wire logic [pio_pkg::ADDR_W-1:0]            avs_address,
   input  wire logic                                  avs_read,
   input  wire logic                                  avs_write,
   input  wire logic [3:0]                            avs_byteenable,
   input  wire logic [pio_pkg::DATA_W-1:0]            avs_writedata,
   output logic      [pio_pkg::DATA_W-1:0]            avs_readdata,
   output logic                                       avs_waitrequest,
   // Port pins.
   input  wire logic [pio_pkg::NPORT-1:0][15:0]       pin_in,
   output logic      [pio_pkg::NPORT-1:0][15:0]       pin_out,
   output logic      [pio_pkg::NPORT-1:0][15:0]       pin_oe,
   // Pad configuration.
   output logic      [pio_pkg::NPORT-1:0][15:0]       pad_driver_control,
   output logic      [pio_pkg::NPORT-1:0][1:0]        thr_sel,
   // Alternate peripheral functions.
   input  wire logic [pio_pkg::NPORT-1:0][15:0]       alt_out,
   input  wire logic [pio_pkg::NPORT-1:0][15:0]       alt_oe,
   output logic      [pio_pkg::NPORT-1:0][15:0]       alt_in,
   // External bus controller.
   input  wire logic [15:0]                           bus_ad_out,
   input  wire logic                                  bus_ad_oe,
   input  wire logic [23:0]                           bus_addr,
   // CAN controller.
   input  wire logic                                  can_tx,
   output logic                                       can_rx,
   // Reset indication pin, always driven.
   output logic                                       reset_indication_output
);

   localparam int NP = pio_pkg::NPORT;

   function automatic int total_lines();
      int s;
      s = 0;
      for (int i = 0; i < NP; i++) begin
         s = s + PORT_W[i];
      end
      total_lines = s;
   endfunction

   // Register offset to one-hot write select; zero for an unmapped offset.
   function automatic logic [pio_pkg::NSEL-1:0] reg_onehot(
      input logic [4:0] ofs);
      logic [pio_pkg::NSEL-1:0] r;
      r = '0;
      if (ofs == pio_pkg::OFS_DATA) r[pio_pkg::SEL_DATA] = 1'b1;
      if (ofs == pio_pkg::OFS_DIR)  r[pio_pkg::SEL_DIR]  = 1'b1;
      if (ofs == pio_pkg::OFS_ODC)  r[pio_pkg::SEL_ODC]  = 1'b1;
      if (ofs == pio_pkg::OFS_ALT)  r[pio_pkg::SEL_ALT]  = 1'b1;
      if (ofs == pio_pkg::OFS_PAD)  r[pio_pkg::SEL_PAD]  = 1'b1;
      if (ofs == pio_pkg::OFS_THR)  r[pio_pkg::SEL_THR]  = 1'b1;
      reg_onehot = r;
   endfunction

   if (total_lines() > pio_pkg::MAX_LINES) begin : g_bad_total
      $error("pio_top: total port width too large");
   end

   // Global configuration.
   logic [3:0] bus_cfg;
   wire        mux_en   = bus_cfg[pio_pkg::BIT_MUX];
   wire        demux_en = bus_cfg[pio_pkg::BIT_DEMUX];
   wire        seg_en   = bus_cfg[pio_pkg::BIT_SEG];
   wire        can_on9  = bus_cfg[pio_pkg::BIT_CAN_SEL];

   // Bus decode.
   wire [2:0]  blk     = avs_address[7:5];
   wire [4:0]  ofs     = {avs_address[4:2], 2'b00};
   wire        is_glb  = (blk == pio_pkg::GLB_BLOCK);
   wire        wr_go   = avs_write & ~avs_waitrequest;
   wire [pio_pkg::NSEL-1:0] sel_hot = reg_onehot(ofs);
   wire [15:0] lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   // With the upper lanes enabled, the upper half is a per-bit write mask.
   wire        use_bmask = avs_byteenable[3] & avs_byteenable[2];
   wire [15:0] wr_mask = use_bmask ? (avs_writedata[31:16] & lane_mask)
                                   : lane_mask;
   wire [15:0] wr_data = avs_writedata[15:0];

   // Override sources in front of the per-port alternate selection.
   logic [NP-1:0][15:0] spec_en;
   logic [NP-1:0][15:0] spec_out;
   logic [NP-1:0][15:0] spec_oe;
   logic [NP-1:0][15:0] alt_sel;
   logic [NP-1:0][15:0] rd_data;
   logic [NP-1:0][15:0] rd_dir;
   logic [NP-1:0][15:0] rd_odc;
   logic [NP-1:0][15:0] rd_pad;
   logic [NP-1:0][1:0]  rd_thr;
   logic [NP-1:0][15:0] port_rd;

   // Address/data port during multiplexed cycles.
   assign spec_en[pio_pkg::P_AD]  = {16{mux_en}};
   assign spec_out[pio_pkg::P_AD] = bus_ad_out;
   assign spec_oe[pio_pkg::P_AD]  = {16{bus_ad_oe}};

   // Address port during demultiplexed cycles.
   assign spec_en[pio_pkg::P_ADDR]  = {16{demux_en}};
   assign spec_out[pio_pkg::P_ADDR] = bus_addr[15:0];
   assign spec_oe[pio_pkg::P_ADDR]  = 16'hffff;

   // Port 4: segment lines, with the CAN pair taking precedence.
   wire        can_on4  = ~can_on9;
   wire [15:0] can4_m   = can_on4 ? (pio_pkg::CAN4_TXM | pio_pkg::CAN4_RXM)
                                  : 16'h0000;
   wire [15:0] seg_en_v = {16{seg_en}} & pio_pkg::SEG_MASK;
   wire [15:0] seg_val  = {8'h00, bus_addr[23:16]};
   wire [15:0] can4_txv = {16{can_tx}} & pio_pkg::CAN4_TXM;
   wire [15:0] can4_oe  = can_on4 ? pio_pkg::CAN4_TXM : 16'h0000;
   assign spec_en[pio_pkg::P_4]  = seg_en_v | can4_m;
   assign spec_out[pio_pkg::P_4] = (seg_val & ~can4_m) | (can4_txv & can4_m);
   assign spec_oe[pio_pkg::P_4]  = (seg_en_v & ~can4_m) | can4_oe;

   // Port 9: the CAN pair when routed here.
   wire [15:0] can9_m   = can_on9 ? (pio_pkg::CAN9_TXM | pio_pkg::CAN9_RXM)
                                  : 16'h0000;
   assign spec_en[pio_pkg::P_9]  = can9_m;
   assign spec_out[pio_pkg::P_9] = {16{can_tx}} & pio_pkg::CAN9_TXM;
   assign spec_oe[pio_pkg::P_9]  = can_on9 ? pio_pkg::CAN9_TXM : 16'h0000;

   for (genvar p = 0; p < NP; p++) begin : g_port
      if (PORT_W[p] < 1 || PORT_W[p] > pio_pkg::PIN_W) begin : g_bad_w
         $error("pio_top: port width out of range");
      end
      if (p == pio_pkg::P_3 || p == pio_pkg::P_IN || p == pio_pkg::P_20)
      begin : g_plain
         assign spec_en[p]  = 16'h0000;
         assign spec_out[p] = 16'h0000;
         assign spec_oe[p]  = 16'h0000;
      end

      // Lines not claimed by a bus or CAN use go to the alternate function where their alt bit is set.
      wire [15:0] ovr_en  = spec_en[p] | alt_sel[p];
      wire [15:0] ovr_out = (spec_en[p] & spec_out[p])
                          | (~spec_en[p] & alt_out[p]);
      wire [15:0] ovr_oe  = (spec_en[p] & spec_oe[p])
                          | (~spec_en[p] & alt_oe[p]);
      wire [pio_pkg::NSEL-1:0] sel =
         (wr_go && !is_glb && blk == 3'(p)) ? sel_hot : '0;

      pio_port #(
         .W       (PORT_W[p]),
         .HAS_OUT (pio_pkg::HAS_OUT[p]),
         .HAS_OD  (pio_pkg::HAS_OD[p]),
         .HAS_THR (pio_pkg::HAS_THR[p]),
         .HAS_PAD (pio_pkg::HAS_PAD[p])
      ) u_port (
         .core_clk (core_clk),
         .rst_n    (rst_n),
         .wr_data  (wr_data),
         .wr_mask  (wr_mask),
         .wr_sel   (sel),
         .ovr_en   (ovr_en),
         .ovr_out  (ovr_out),
         .ovr_oe   (ovr_oe),
         .pin_in   (pin_in[p]),
         .pin_out  (pin_out[p]),
         .pin_oe   (pin_oe[p]),
         .pin_sync (alt_in[p]),
         .rd_data  (rd_data[p]),
         .rd_dir   (rd_dir[p]),
         .rd_odc   (rd_odc[p]),
         .rd_alt   (alt_sel[p]),
         .rd_pad   (rd_pad[p]),
         .rd_thr   (rd_thr[p])
      );

      assign pad_driver_control[p] = rd_pad[p];
      assign thr_sel[p]            = rd_thr[p];

      assign port_rd[p] =
           sel_hot[pio_pkg::SEL_DATA] ? rd_data[p]
         : sel_hot[pio_pkg::SEL_DIR]  ? rd_dir[p]
         : sel_hot[pio_pkg::SEL_ODC]  ? rd_odc[p]
         : sel_hot[pio_pkg::SEL_ALT]  ? alt_sel[p]
         : sel_hot[pio_pkg::SEL_PAD]  ? rd_pad[p]
         : sel_hot[pio_pkg::SEL_THR]  ? {14'h0000, rd_thr[p]}
         : 16'h0000;
   end

   // Global register read and the final read selection.
   wire [15:0] glb_rd =
        (ofs == pio_pkg::OFS_BUS) ? {12'h000, bus_cfg}
      : (ofs == pio_pkg::OFS_SYS) ? {15'h0000, reset_indication_output}
      : 16'h0000;
   wire [15:0] rd_word = is_glb ? glb_rd : port_rd[blk];
   wire [15:0] glb_m4  = wr_mask & 16'h000f;
   wire        glb_bus_wr = wr_go & is_glb & (ofs == pio_pkg::OFS_BUS);
   wire        glb_sys_wr = wr_go & is_glb & (ofs == pio_pkg::OFS_SYS);
   wire [15:0] next_bus = pio_pkg::masked_write({12'h000, bus_cfg},
                                                wr_data, glb_m4);

   // One wait cycle per transfer; the answer stands at the released edge.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= pio_pkg::RST_WAIT;
         avs_readdata    <= '0;
      end else if ((avs_read || avs_write) && avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
         if (avs_read)
            avs_readdata <= {16'h0000, rd_word};
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_cfg <= pio_pkg::RST_BUS;
      end else if (glb_bus_wr) begin
         bus_cfg <= next_bus[3:0];
      end
   end

   // Reset indication stays low through reset until software releases it.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reset_indication_output <= pio_pkg::RST_SYS;
      end else if (glb_sys_wr && wr_mask[pio_pkg::BIT_RST_REL]) begin
         reset_indication_output <= wr_data[pio_pkg::BIT_RST_REL];
      end
   end

   // The CAN receive line follows whichever port carries the pair.
   wire can_rx4 = |(alt_in[pio_pkg::P_4] & pio_pkg::CAN4_RXM);
   wire can_rx9 = |(alt_in[pio_pkg::P_9] & pio_pkg::CAN9_RXM);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         can_rx <= 1'b1;
      end else begin
         can_rx <= can_on9 ? can_rx9 : can_rx4;
      end
   end

endmodule
`default_nettype wire

// [dv/pio_board.sv]
`default_nettype none
module pio_board (
   // Device side.
   input  wire logic [6:0][15:0] pin_out,
   input  wire logic [6:0][15:0] pin_oe,
   // Board side.
   input  wire logic [6:0][15:0] ext_en,
   input  wire logic [6:0][15:0] ext_val,
   output logic      [6:0][15:0] pin_in
);
   timeunit 1ns;
   timeprecision 100ps;
   // A line that nobody drives settles to the board pull-up level.
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                 | (~pin_oe & ~ext_en);
endmodule
`default_nettype wire

// [dv/pio_top_chk.sv]
`default_nettype none
module pio_top_chk #(
   parameter int PORT_W [pio_pkg::NPORT] = pio_pkg::PORT_W_DEF
) (
   input wire logic                            core_clk,
   input wire logic                            rst_n,
   input wire logic                            avs_read,
   input wire logic                            avs_write,
   input wire logic [pio_pkg::DATA_W-1:0]      avs_readdata,
   input wire logic                            avs_waitrequest,
   input wire logic [pio_pkg::NPORT-1:0][15:0] pin_in,
   input wire logic [pio_pkg::NPORT-1:0][15:0] pin_oe,
   input wire logic [pio_pkg::NPORT-1:0][15:0] alt_in,
   input wire logic [pio_pkg::NPORT-1:0][15:0] pad_driver_control,
   input wire logic [pio_pkg::NPORT-1:0][1:0]  thr_sel,
   input wire logic                            reset_indication_output
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [pio_pkg::NPORT-1:0][15:0] over;
   for (genvar p = 0; p < pio_pkg::NPORT; p++) begin : g_over
      assign over[p] = ~16'((32'h1 << PORT_W[p]) - 32'h1);
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence req_taken;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence answer_pulse;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   one_wait_a: assert property (req_taken |=> answer_pulse)
      else $error("bus answer is not one single cycle");
   ans_cause_a: assert property ($fell(avs_waitrequest) |->
      $past(avs_read || avs_write)) else $error("answer without request");
   data_upper_a: assert property (avs_readdata[31:16] == 16'h0)
      else $error("read data upper half not zero");
   rst_input_a: assert property ($rose(rst_n) |->
      pin_oe == '0 && !reset_indication_output)
      else $error("pins driven at reset release");
   in_only_a: assert property (pin_oe[pio_pkg::P_IN] == 16'h0
      && (pin_oe & over) == '0) else $error("missing line driven");
   sync_pin_a: assert property ($past(rst_n, 2) && $past(rst_n)
      |-> alt_in[0] == $past(pin_in[0], 2))
      else $error("pin sync lag wrong");
   pad_fixed_a: assert property
      (pad_driver_control[pio_pkg::P_IN] == 16'h0)
      else $error("pad control on input port");
   thr_fixed_a: assert property (thr_sel[0] == 2'h0 &&
      thr_sel[1] == 2'h0 && thr_sel[4] == 2'h0 && thr_sel[6] == 2'h0
      && !thr_sel[5][1]) else $error("threshold on port without it");
   ind_cause_a: assert property ($rose(reset_indication_output) |->
      $past(avs_write) || $past(avs_write, 2))
      else $error("reset indication rose without write");
endmodule
bind pio_top pio_top_chk #(.PORT_W(PORT_W)) u_chk (
   .core_clk(core_clk), .rst_n(rst_n), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_oe(pin_oe),
   .alt_in(alt_in), .pad_driver_control(pad_driver_control),
   .thr_sel(thr_sel), .reset_indication_output(reset_indication_output)
);
`default_nettype wire

// [dv/pio_top_tb.sv]
`default_nettype none
module pio_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic             core_clk, rst_n, avs_read, avs_write, avs_waitrequest;
   logic [7:0]       avs_address;
   logic [3:0]       avs_byteenable;
   logic [31:0]      avs_writedata, avs_readdata, q;
   logic [6:0][15:0] pin_in, pin_out, pin_oe, pdc, alt_out, alt_oe, alt_in;
   logic [6:0][15:0] ext_en, ext_val;
   logic [6:0][1:0]  thr_sel;
   logic [15:0]      bus_ad_out;
   logic [23:0]      bus_addr;
   logic             bus_ad_oe, can_tx, can_rx, rst_ind;
   int               fail_count, checks_done;

   pio_top dut (.core_clk(core_clk), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_byteenable(avs_byteenable),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .pad_driver_control(pdc),
      .thr_sel(thr_sel), .alt_out(alt_out), .alt_oe(alt_oe),
      .alt_in(alt_in), .bus_ad_out(bus_ad_out), .bus_ad_oe(bus_ad_oe),
      .bus_addr(bus_addr), .can_tx(can_tx), .can_rx(can_rx),
      .reset_indication_output(rst_ind));
   pio_board board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
      .ext_val(ext_val), .pin_in(pin_in));

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Upper write half is the per-bit mask of the lower half.
   task automatic wr(input logic [7:0] a, input logic [15:0] m,
                     input logic [15:0] d);
      avs_address <= a;
      avs_writedata <= {m, d};
      avs_write <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask

   task automatic rd(input logic [7:0] a);
      avs_address <= a;
      avs_read <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic s_reset();
      rst_n <= 1'b0;
      repeat (5) @(posedge core_clk);
      for (int p = 0; p < 7; p++) chk(32'(pin_oe[p]), 32'h0);
      chk(32'(rst_ind), 32'h0);
      rst_n <= 1'b1;
      @(posedge core_clk);
      wr(8'he4, 16'h0001, 16'h0001);
      chk(32'(rst_ind), 32'h1);
   endtask

   task automatic s_dir();
      wr(8'h04, 16'h0008, 16'hffff);
      wr(8'h00, 16'h0008, 16'h0008);
      wr(8'h04, 16'h0020, 16'hffff);
      chk(32'(pin_oe[0]), 32'h0028);
      chk(32'(pin_out[0] & pin_oe[0]), 32'h0008);
      ext_val[0] <= 16'ha5c3;
      repeat (4) @(posedge core_clk);
      rd(8'h00);
      chk(q, 32'ha5cb);
      rd(8'h04);
      chk(q, 32'h0028);
      rd(8'h18);
      chk(q, 32'h0);
      wr(8'h08, 16'hffff, 16'hffff);
      rd(8'h08);
      chk(q, 32'h0);
   endtask

   task automatic s_od();
      wr(8'h44, 16'h0003, 16'h0003);
      wr(8'h40, 16'h0003, 16'h0001);
      chk(32'(pin_oe[2][1:0]), 32'h3);
      wr(8'h48, 16'h0003, 16'h0003);
      chk(32'({pin_oe[2][1:0], pin_out[2][1]}), 32'h4);
   endtask

   task automatic s_cfg();
      wr(8'h50, 16'hffff, 16'h1234);
      chk(32'(pdc[2]), 32'h1234);
      // Without both upper lanes the enabled low lanes form the mask.
      avs_byteenable <= 4'h2;
      wr(8'h50, 16'h0000, 16'hab00);
      avs_byteenable <= 4'hf;
      chk(32'(pdc[2]), 32'hab34);
      wr(8'h90, 16'hffff, 16'h1234);
      chk(32'(pdc[4]), 32'h0);
      wr(8'h54, 16'h0003, 16'h0003);
      chk(32'(thr_sel[2]), 32'h3);
      wr(8'h54, 16'h0003, 16'h0001);
      chk(32'(thr_sel[2]), 32'h1);
      wr(8'h54, 16'h0002, 16'h0002);
      chk(32'(thr_sel[2]), 32'h3);
      alt_out[2] <= 16'h0010;
      alt_oe[2] <= 16'h0010;
      wr(8'h4c, 16'h0010, 16'h0010);
      chk(32'(pin_oe[2] & 16'h0013), 32'h0012);
      chk(32'(pin_out[2][4]), 32'h1);
   endtask

   task automatic s_can();
      can_tx <= 1'b0;
      ext_val[3][6] <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk(32'({pin_oe[3][7], pin_out[3][7], can_rx}), 32'h4);
      wr(8'he0, 16'h0008, 16'h0008);
      repeat (2) @(posedge core_clk);
      chk(32'({pin_oe[3][7], pin_oe[5][1], pin_out[5][1], can_rx}),
          32'h5);
      can_tx <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk(32'(pin_out[5][1]), 32'h1);
   endtask

   task automatic s_bus();
      bus_ad_out <= 16'h5a3c;
      bus_ad_oe <= 1'b1;
      bus_addr <= 24'h9e7b61;
      repeat (2) @(posedge core_clk);
      chk(32'(pin_oe[3][7:0]), 32'h0);
      wr(8'he0, 16'h0007, 16'h0007);
      chk({pin_out[0], pin_oe[0]}, 32'h5a3cffff);
      chk({pin_out[1], pin_oe[1]}, 32'h7b61ffff);
      chk(32'({pin_out[3][7:0], pin_oe[3][7:0]}), 32'h9eff);
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge core_clk);
      fail_count++;
      results();
   end

   initial begin
      rst_n = 1'b0;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_byteenable = 4'hf;
      avs_writedata = 32'h0;
      alt_out = '0;
      alt_oe = '0;
      ext_en = '1;
      ext_val = '1;
      ext_val[0] = 16'h0000;
      bus_ad_out = 16'h0000;
      bus_ad_oe = 1'b0;
      bus_addr = 24'h000000;
      can_tx = 1'b1;
      fail_count = 0;
      checks_done = 0;
      s_reset();
      s_dir();
      s_od();
      s_cfg();
      s_can();
      s_bus();
      s_reset();
      results();
   end
endmodule
`default_nettype wire
